// ---- pscd_cycle_decode.sv ----
// cycle decoder, burst counter, pipeline and memory array of the burst sram
`timescale 1ns/1ns
`default_nettype none
module pscd_cycle_decode (
   input  wire logic                         sys_clk_i,
   input  wire logic                         reset_n_i,
   input  wire logic [pscd_pkg::ADDR_W-1:0]  addr_i,
   input  wire logic                         chip_sel1_n_i,
   input  wire logic                         chip_sel2_i,
   input  wire logic                         chip_sel3_n_i,
   input  wire logic                         load_or_step_i,
   input  wire logic                         write_strobe_n_i,
   input  wire logic [pscd_pkg::LANES-1:0]   byte_write_select_n_i,
   input  wire logic                         clock_enable_n_i,
   input  wire logic                         sleep_request_i,
   input  wire logic                         out_enable_n_i,
   input  wire logic                         burst_order_i,
   input  wire logic [pscd_pkg::DATA_W-1:0]  data_i,
   input  wire logic [pscd_pkg::LANES-1:0]   parity_lines_i,
   output logic      [pscd_pkg::DATA_W-1:0]  data_o,
   output logic      [pscd_pkg::LANES-1:0]   parity_lines_o,
   output logic                              data_oe_o
);
   // ************************************************************
   // declarations
   // ************************************************************
   logic [pscd_pkg::WORD_W-1:0]  mem [0:pscd_pkg::DEPTH-1];
   pscd_pkg::pscd_cyc_t          mode_ff;
   pscd_pkg::pscd_cyc_t          nxt_mode;
   logic [pscd_pkg::ADDR_W-1:0]  base_ff;
   logic [pscd_pkg::ADDR_W-1:0]  nxt_base;
   logic [pscd_pkg::BURST_W-1:0] cnt_ff;
   logic [pscd_pkg::BURST_W-1:0] nxt_cnt;
   pscd_pkg::pscd_cmd_t          nxt_cmd;
   pscd_pkg::pscd_cmd_t          ph1_ff;
   pscd_pkg::pscd_cmd_t          ph2_ff;
   logic [pscd_pkg::WORD_W-1:0]  rd_word_ff;
   logic                         drive_ff;
   logic [pscd_pkg::WORD_W-1:0]  read_view;
   logic                         cs_all;
   logic                         advance;
   logic                         read_issue;
   pscd_pkg::pscd_wr_t           cap;
   logic                         cap_valid;
   logic                         cap_due;
   logic                         buf_in_ready;
   logic                         buf_out_valid;
   logic                         buf_out_ready;
   pscd_pkg::pscd_wr_t           buf_head;
   pscd_pkg::pscd_wr_t           buf_newer;
   logic                         buf_newer_valid;

   // ************************************************************
   // edge qualification
   // ************************************************************
   // a full buffer only waits when a capture is due; pipeline spacing keeps that from arising
   assign advance = ~clock_enable_n_i & ~sleep_request_i & (buf_in_ready | ~cap_due); // R7
   assign cs_all  = ~chip_sel1_n_i & chip_sel2_i & ~chip_sel3_n_i;

   // ************************************************************
   // command decode and burst counter
   // ************************************************************
   // load starts or deselects, step continues the latched burst type
   always_comb begin
      nxt_base = base_ff;
      nxt_cnt  = cnt_ff;
      nxt_mode = mode_ff;
      if (!load_or_step_i) begin
         if (cs_all) begin
            nxt_base = addr_i; // R17
            nxt_cnt  = pscd_pkg::RST_CNT;
            nxt_mode = write_strobe_n_i ? pscd_pkg::CYC_READ : pscd_pkg::CYC_WRITE; // R2 R3
         end else begin
            nxt_mode = pscd_pkg::CYC_NONE; // R1
         end
      end else begin
         nxt_cnt = 2'(cnt_ff + 2'h1); // R13
      end
      nxt_cmd.kind  = nxt_mode;
      nxt_cmd.addr  = pscd_pkg::burst_addr(nxt_base, nxt_cnt, burst_order_i); // R14
      nxt_cmd.sel_n = byte_write_select_n_i; // R2 byte selects matter only on writes
   end

   // burst state, held on ignored edges
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         mode_ff <= pscd_pkg::CYC_NONE; // R8
         base_ff <= pscd_pkg::RST_ADDR;
         cnt_ff  <= pscd_pkg::RST_CNT;
      end else if (sleep_request_i) begin
         mode_ff <= pscd_pkg::CYC_NONE; // R16
      end else if (advance) begin
         mode_ff <= nxt_mode;
         base_ff <= nxt_base;
         cnt_ff  <= nxt_cnt;
      end
   end

   // ************************************************************
   // pipeline stages
   // ************************************************************
   // ph1 is the command after its edge, ph2 the write awaiting its data
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         ph1_ff <= '{kind: pscd_pkg::CYC_NONE, addr: pscd_pkg::RST_ADDR,
                     sel_n: pscd_pkg::NO_LANES};
         ph2_ff <= '{kind: pscd_pkg::CYC_NONE, addr: pscd_pkg::RST_ADDR,
                     sel_n: pscd_pkg::NO_LANES};
      end else if (sleep_request_i) begin
         ph1_ff.kind <= pscd_pkg::CYC_NONE; // R16
         ph2_ff.kind <= pscd_pkg::CYC_NONE;
      end else if (advance) begin
         ph1_ff <= nxt_cmd;
         ph2_ff <= ph1_ff; // R15
      end
   end

   // ************************************************************
   // read data and driver state
   // ************************************************************
   // newest pending data wins: array, buffer head, newer entry, capture
   always_comb begin
      read_view = mem[ph1_ff.addr];
      read_view = pscd_pkg::forward(read_view, ph1_ff.addr, buf_head, buf_out_valid);
      read_view = pscd_pkg::forward(read_view, ph1_ff.addr, buf_newer, buf_newer_valid);
      read_view = pscd_pkg::forward(read_view, ph1_ff.addr, cap, cap_valid);
   end

   // output register loads one edge after the read command
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         drive_ff   <= 1'b0; // R8
         rd_word_ff <= pscd_pkg::RST_WORD;
      end else if (sleep_request_i) begin
         drive_ff <= 1'b0; // R16
      end else if (advance) begin
         unique case (ph1_ff.kind)
            pscd_pkg::CYC_READ: begin
               drive_ff   <= 1'b1; // R12
               rd_word_ff <= read_view;
            end
            pscd_pkg::CYC_WRITE: begin
               drive_ff <= 1'b0; // R6 R10 R15
            end
            default: begin
               drive_ff <= 1'b0; // R1 R11
            end
         endcase
      end
   end

   // output enable acts without the clock on the drivers
   assign data_oe_o = drive_ff & ~out_enable_n_i & ~sleep_request_i; // R9 R11

   // unpack the output word into data and parity lines
   always_comb begin
      for (int i = 0; i < pscd_pkg::LANES; i++) begin
         data_o[i*8 +: 8]  = rd_word_ff[i*pscd_pkg::LANE_W +: 8];
         parity_lines_o[i] = rd_word_ff[i*pscd_pkg::LANE_W + 8];
      end
   end

   // ************************************************************
   // write capture, buffer and array
   // ************************************************************
   // data sampled two edges after the write; all-high selects store nothing
   assign cap.addr  = ph2_ff.addr;
   assign cap.word  = pscd_pkg::pack(data_i, parity_lines_i);
   assign cap.sel_n = ph2_ff.sel_n;
   assign cap_due   = (ph2_ff.kind == pscd_pkg::CYC_WRITE) & ~&ph2_ff.sel_n; // R4
   assign cap_valid = advance & cap_due; // R15

   // the array port goes to reads first, so the buffer drains between them
   assign read_issue    = advance & (ph1_ff.kind == pscd_pkg::CYC_READ);
   assign buf_out_ready = ~read_issue;

   pscd_wr_buffer u_wr_buffer (
      .sys_clk_i     (sys_clk_i),
      .reset_n_i     (reset_n_i),
      .in_valid_i    (cap_valid),
      .in_data_i     (cap),
      .in_ready_o    (buf_in_ready),
      .out_valid_o   (buf_out_valid),
      .out_ready_i   (buf_out_ready),
      .out_data_o    (buf_head),
      .newer_data_o  (buf_newer),
      .newer_valid_o (buf_newer_valid)
   );

   // array write keeps unselected lanes
   always_ff @(posedge sys_clk_i) begin
      if (buf_out_valid && buf_out_ready) begin
         mem[buf_head.addr] <= pscd_pkg::merge(mem[buf_head.addr], buf_head.word,
                                               buf_head.sel_n); // R5
      end
   end
endmodule
`default_nettype wire

// ---- pscd_pkg.sv ----
// constants, types and helper functions for the pipelined sram cycle decoder
// Functional notes
// R1 - new access needs all three chip selects; otherwise deselect, data lines off
// R2 - selected, load low, write strobe high: read burst; drive if output enable low
// R3 - selected, load low, write strobe low, a byte select low: write burst
// R4 - write with all byte selects high stores nothing; burst address still steps
// R5 - any byte select mix allowed; only selected lanes with parity are stored
// R6 - decoded write cycle turns all data and parity drivers off
// R7 - clock enable high ignores the edge; address, burst and pipeline hold
// R8 - after power-up the device is deselected with data lines off
// R9 - output enable gates drivers combinationally and is never registered
// R10 - output enable is masked internally during write cycles
// R11 - read data driven only while output enable active and device selected
// R12 - driver state follows the cycle in the data phase, not the new command
// R13 - load high continues the burst, ignoring chip selects and write strobe
// R14 - four-beat wrapping burst on two low bits, linear or interleaved order
// R15 - drivers off one edge after a write; data captured two edges after it
// R16 - sleep request forces data lines off and ignores all other inputs
// R17 - address sampled only at burst start; continuing beats use the counter
package pscd_pkg;

   // ************************************************************
   // sizes
   // ************************************************************
   localparam int ADDR_W  = 19;
   localparam int DEPTH   = 524288;
   localparam int LANES   = 4;
   localparam int LANE_W  = 9;
   localparam int DATA_W  = 32;
   localparam int WORD_W  = 36;
   localparam int BURST_W = 2;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [ADDR_W-1:0]  RST_ADDR = 19'h00000;
   localparam logic [BURST_W-1:0] RST_CNT  = 2'h0;
   localparam logic [WORD_W-1:0]  RST_WORD = 36'h000000000;
   localparam logic [LANES-1:0]   NO_LANES = 4'hF;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {
      CYC_NONE  = 2'b00,
      CYC_READ  = 2'b01,
      CYC_WRITE = 2'b11
   } pscd_cyc_t;

   typedef struct packed {
      pscd_cyc_t         kind;
      logic [ADDR_W-1:0] addr;
      logic [LANES-1:0]  sel_n;
   } pscd_cmd_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] word;
      logic [LANES-1:0]  sel_n;
   } pscd_wr_t;

   // ************************************************************
   // functions
   // ************************************************************
   // next burst address from base and beat count
   function automatic logic [ADDR_W-1:0] burst_addr(input logic [ADDR_W-1:0] base,
                                                    input logic [BURST_W-1:0] cnt,
                                                    input logic interleave);
      logic [BURST_W-1:0] low;
      low = interleave ? (base[BURST_W-1:0] ^ cnt) : 2'(base[BURST_W-1:0] + cnt); // R14
      return {base[ADDR_W-1:BURST_W], low};
   endfunction

   // overlay selected lanes of a new word on an old one
   function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] old_w,
                                               input logic [WORD_W-1:0] new_w,
                                               input logic [LANES-1:0]  sel_n);
      logic [WORD_W-1:0] res;
      res = old_w;
      for (int i = 0; i < LANES; i++) begin
         if (!sel_n[i]) begin
            res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W]; // R5
         end
      end
      return res;
   endfunction

   // overlay a pending write when its address matches
   function automatic logic [WORD_W-1:0] forward(input logic [WORD_W-1:0] word,
                                                 input logic [ADDR_W-1:0] addr,
                                                 input pscd_wr_t          ent,
                                                 input logic              valid);
      return (valid && ent.addr == addr) ? merge(word, ent.word, ent.sel_n) : word;
   endfunction

   // lane i holds parity bit i above data byte i
   function automatic logic [WORD_W-1:0] pack(input logic [DATA_W-1:0] data,
                                              input logic [LANES-1:0]  par);
      logic [WORD_W-1:0] res;
      res = RST_WORD;
      for (int i = 0; i < LANES; i++) begin
         res[i*LANE_W +: LANE_W] = {par[i], data[i*8 +: 8]};
      end
      return res;
   endfunction

endpackage

// ---- pscd_wr_buffer.sv ----
// two-entry write buffer between data capture and the memory array
`timescale 1ns/1ns
`default_nettype none
module pscd_wr_buffer (
   input  wire logic               sys_clk_i,
   input  wire logic               reset_n_i,
   input  wire logic               in_valid_i,
   input  wire pscd_pkg::pscd_wr_t in_data_i,
   output logic                    in_ready_o,
   output logic                    out_valid_o,
   input  wire logic               out_ready_i,
   output var pscd_pkg::pscd_wr_t  out_data_o,
   output var pscd_pkg::pscd_wr_t  newer_data_o,
   output logic                    newer_valid_o
);
   pscd_pkg::pscd_wr_t slot_ff [0:1];
   logic               wr_ptr_ff;
   logic               rd_ptr_ff;
   logic [1:0]         count_ff;
   logic               push;
   logic               pop;

   // handshake and views, oldest entry first
   assign push          = in_valid_i & in_ready_o;
   assign pop           = out_valid_o & out_ready_i;
   assign in_ready_o    = (count_ff != 2'h2);
   assign out_valid_o   = (count_ff != 2'h0);
   assign newer_valid_o = (count_ff == 2'h2);
   assign out_data_o    = slot_ff[rd_ptr_ff];
   assign newer_data_o  = slot_ff[~rd_ptr_ff];

   // entry storage
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         slot_ff[wr_ptr_ff] <= in_data_i;
      end
   end

   // pointers and fill level
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i) begin
         wr_ptr_ff <= 1'b0;
         rd_ptr_ff <= 1'b0;
         count_ff  <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_ff <= ~wr_ptr_ff;
         end
         if (pop) begin
            rd_ptr_ff <= ~rd_ptr_ff;
         end
         count_ff <= 2'(count_ff + {1'b0, push} - {1'b0, pop});
      end
   end
endmodule
`default_nettype wire

// ---- pscd_cycle_decode_chk.sv ----
// driver-state assertions for the pipelined sram cycle decoder
`timescale 1ns/1ns
`default_nettype none
module pscd_cycle_decode_chk (
   input wire logic                        sys_clk_i,
   input wire logic                        reset_n_i,
   input wire logic                        chip_sel1_n_i,
   input wire logic                        chip_sel2_i,
   input wire logic                        chip_sel3_n_i,
   input wire logic                        load_or_step_i,
   input wire logic                        write_strobe_n_i,
   input wire logic                        clock_enable_n_i,
   input wire logic                        sleep_request_i,
   input wire logic                        out_enable_n_i,
   input wire logic [pscd_pkg::DATA_W-1:0] data_o,
   input wire logic [pscd_pkg::LANES-1:0]  parity_lines_o,
   input wire logic                        data_oe_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   // edge decode as seen from the pins
   wire logic adv = !clock_enable_n_i && !sleep_request_i;
   wire logic sel = !chip_sel1_n_i && chip_sel2_i && !chip_sel3_n_i;
   wire logic ld  = adv && !load_or_step_i;
   wire logic rd  = ld && sel && write_strobe_n_i;
   wire logic wr  = ld && sel && !write_strobe_n_i;
   wire logic ds  = ld && !sel;
   wire logic st  = adv && load_or_step_i;
   wire logic on  = out_enable_n_i || sleep_request_i || data_oe_o;

   AST_RESET_IDLE: assert property ($rose(reset_n_i) |-> !data_oe_o)
      else $error("drivers on right after reset");
   AST_DESELECT_OFF: assert property (ds ##1 adv |=> !data_oe_o)
      else $error("drivers on after deselect");
   AST_READ_DRIVES: assert property (rd ##1 adv |=> on)
      else $error("read data phase not driven");
   AST_WRITE_OFF: assert property (wr ##1 adv |=> !data_oe_o)
      else $error("drivers on in write data phase");
   AST_OE_GATES: assert property (out_enable_n_i |-> !data_oe_o)
      else $error("drivers on with output enable off");
   AST_SLEEP_OFF: assert property (sleep_request_i |-> !data_oe_o)
      else $error("drivers on during sleep");
   AST_STALL_HOLDS: assert property (clock_enable_n_i && !sleep_request_i
      |=> $stable({parity_lines_o, data_o}))
      else $error("read data moved on an ignored edge");
   AST_STEP_KEEPS: assert property ((wr || ds) ##1 st ##1 adv |=> !data_oe_o)
      else $error("continued write or deselect drove the bus");
   AST_READ_STEP: assert property (rd ##1 st ##1 adv |=> on)
      else $error("continued read not driven");

   CV_READ: cover property (rd ##2 data_oe_o);
   CV_STALL: cover property (rd ##1 clock_enable_n_i);
   CV_SLEEP: cover property (sleep_request_i);
endmodule
bind pscd_cycle_decode pscd_cycle_decode_chk chk (.sys_clk_i(sys_clk_i),
   .reset_n_i(reset_n_i), .chip_sel1_n_i(chip_sel1_n_i), .chip_sel2_i(chip_sel2_i),
   .chip_sel3_n_i(chip_sel3_n_i), .load_or_step_i(load_or_step_i),
   .write_strobe_n_i(write_strobe_n_i), .clock_enable_n_i(clock_enable_n_i),
   .sleep_request_i(sleep_request_i), .out_enable_n_i(out_enable_n_i),
   .data_o(data_o), .parity_lines_o(parity_lines_o), .data_oe_o(data_oe_o));
`default_nettype wire

// ---- pscd_ctl_model.sv ----
// behavioural memory controller that drives the sram command and data pins
`timescale 1ns/1ns
`default_nettype none
module pscd_ctl_model (
   input  wire logic        sys_clk_i,
   output logic [18:0]      addr_o,
   output logic             chip_sel1_n_o,
   output logic             chip_sel2_o,
   output logic             chip_sel3_n_o,
   output logic             load_or_step_o,
   output logic             write_strobe_n_o,
   output logic [3:0]       byte_write_select_n_o,
   output logic             clock_enable_n_o,
   output logic             sleep_request_o,
   output logic             out_enable_n_o,
   output logic             burst_order_o,
   output logic [31:0]      data_o,
   output logic [3:0]       parity_lines_o
);
   logic [35:0] p0_d, p1_d, cur_d;
   logic        p0_v, p1_v, cur_v, wr_burst;
   // idle pins: deselected, output enable on, linear order
   initial begin
      {chip_sel1_n_o, chip_sel2_o, chip_sel3_n_o, write_strobe_n_o} = 4'hB;
      {load_or_step_o, clock_enable_n_o, sleep_request_o} = 3'h0;
      {out_enable_n_o, burst_order_o} = 2'h0;
      byte_write_select_n_o = 4'hF;
      addr_o = 19'h00000;
      {p0_v, p1_v, cur_v, wr_burst} = 4'h0;
      {parity_lines_o, data_o} = 36'h000000000;
   end
   // write data pipe: taken at edge n, driven after n+1, captured at n+2
   always @(posedge sys_clk_i) begin
      if (!clock_enable_n_o && !sleep_request_o) begin
         {p1_v, p1_d} <= {p0_v, p0_d};
         {p0_v, p0_d} <= {cur_v, cur_d};
      end
      #1;
      // released lines toggle so a stale value never looks valid
      {parity_lines_o, data_o} <= p1_v ? p1_d : ~{parity_lines_o, data_o};
   end
   // one bus cycle: drive just after an edge and hold until the next edge
   task automatic beat(input logic ld, input logic [2:0] cs, input logic wn,
                       input logic [3:0] sel, input logic [18:0] a,
                       input logic [35:0] wd, input logic clock_enable_n);
      {chip_sel3_n_o, chip_sel2_o, chip_sel1_n_o} = cs ^ 3'h5;
      load_or_step_o = ld;
      write_strobe_n_o = wn;
      byte_write_select_n_o = sel;
      addr_o = a;
      clock_enable_n_o = clock_enable_n;
      if (!ld && !clock_enable_n) wr_burst = (cs == 3'h7) && !wn;
      cur_v = !clock_enable_n && !sleep_request_o && wr_burst;
      cur_d = wd;
      @(posedge sys_clk_i);
      #1;
   endtask
endmodule
`default_nettype wire

// ---- pscd_cycle_decode_tb.sv ----
// self-checking testbench for the pipelined sram cycle decoder
`timescale 1ns/1ns
`default_nettype none
module pscd_cycle_decode_tb;
   logic             sys_clk_i;
   logic             reset_n_i;
   int               n_fail;
   int               comparisons;
   logic [35:0]      w [4];
   wire logic [18:0] addr;
   wire logic [31:0] wdat, rdat;
   wire logic [3:0]  wpar, rpar, bsel;
   wire logic        cs1_n, cs2, cs3_n, ld, we_n, cen_n, slp, oe_n, mode, oe;
   wire logic [35:0] rdw = {rpar, rdat};

   pscd_ctl_model ctl (.sys_clk_i(sys_clk_i), .addr_o(addr), .chip_sel1_n_o(cs1_n),
      .chip_sel2_o(cs2), .chip_sel3_n_o(cs3_n), .load_or_step_o(ld),
      .write_strobe_n_o(we_n), .byte_write_select_n_o(bsel), .clock_enable_n_o(cen_n),
      .sleep_request_o(slp), .out_enable_n_o(oe_n), .burst_order_o(mode),
      .data_o(wdat), .parity_lines_o(wpar));
   pscd_cycle_decode dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .addr_i(addr),
      .chip_sel1_n_i(cs1_n), .chip_sel2_i(cs2), .chip_sel3_n_i(cs3_n),
      .load_or_step_i(ld), .write_strobe_n_i(we_n), .byte_write_select_n_i(bsel),
      .clock_enable_n_i(cen_n), .sleep_request_i(slp), .out_enable_n_i(oe_n),
      .burst_order_i(mode), .data_i(wdat), .parity_lines_i(wpar), .data_o(rdat),
      .parity_lines_o(rpar), .data_oe_o(oe));

   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   // ************************************************************
   // helpers
   // ************************************************************
   task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic idle();
      ctl.beat(1'b0, 3'h0, 1'b1, 4'hF, 19'h00000, 36'h000000000, 1'b0);
   endtask
   task automatic rd(input logic [18:0] a);
      ctl.beat(1'b0, 3'h7, 1'b1, 4'hF, a, 36'h000000000, 1'b0);
   endtask
   task automatic wr(input logic [18:0] a, input logic [3:0] s, input logic [35:0] d);
      ctl.beat(1'b0, 3'h7, 1'b0, s, a, d, 1'b0);
   endtask
   task automatic step(input logic [3:0] s, input logic [35:0] d);
      ctl.beat(1'b1, 3'h0, 1'b1, s, 19'h7FFFF, d, 1'b0);
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_bytes();
      logic [3:0]  sels [7] = '{4'hE, 4'hD, 4'hB, 4'h7, 4'h5, 4'hA, 4'hF};
      logic [35:0] exp;
      logic [35:0] nv;
      exp = 36'h123456789;
      wr(19'h00010, 4'h0, exp);
      idle();
      foreach (sels[k]) begin
         nv = ~exp ^ 36'(k);
         rd(19'h00010);
         wr(19'h00010, sels[k], nv);
         chk("merged word", exp, rdw);
         chk("read drive", 36'h000000001, 36'(oe));
         idle();
         chk("write drive", 36'h000000000, 36'(oe));
         for (int i = 0; i < 4; i++) begin
            if (!sels[k][i]) begin
               exp[8*i +: 8] = nv[8*i +: 8];
               exp[32+i] = nv[32+i];
            end
         end
      end
      rd(19'h00010);
      idle();
      chk("last merged word", exp, rdw);
   endtask
   task automatic t_burst();
      logic [1:0] a;
      for (int i = 0; i < 4; i++) w[i] = 36'h800000000 + 36'(i) * 36'h012345679;
      wr(19'h00022, 4'h0, w[2]);
      wr(19'h00020, 4'h0, w[0]);
      step(4'h0, w[1]);
      step(4'hF, 36'h000000000);
      step(4'h0, w[3]);
      idle();
      for (int m = 0; m < 2; m++) begin
         ctl.burst_order_o = m[0];
         for (int s = 1; s < 4; s += 2) begin
            rd(19'h00020 + 19'(s));
            for (int k = 0; k < 4; k++) begin
               if (k < 3) step(4'hF, 36'h000000000);
               else idle();
               a = m[0] ? (2'(s) ^ 2'(k)) : 2'(s + k);
               chk("burst word", w[a], rdw);
            end
         end
      end
   endtask
   task automatic t_oe_stall();
      ctl.out_enable_n_o = 1'b1;
      rd(19'h00020);
      idle();
      chk("dummy read drive", 36'h000000000, 36'(oe));
      ctl.out_enable_n_o = 1'b0;
      #1;
      chk("enable without edge", 36'h000000001, 36'(oe));
      chk("dummy read word", w[0], rdw);
      @(posedge sys_clk_i);
      #1;
      rd(19'h00021);
      ctl.beat(1'b1, 3'h0, 1'b1, 4'hF, 19'h7FFFF, 36'h000000000, 1'b1);
      chk("stalled drive", 36'h000000000, 36'(oe));
      idle();
      chk("word after stall", w[1], rdw);
   endtask
   task automatic t_desel_sleep();
      for (int c = 0; c < 3; c++) begin
         rd(19'h00023);
         ctl.beat(1'b0, 3'h7 ^ (3'h1 << c), 1'b1, 4'hF, 19'h00020, 36'h000000000, 1'b0);
         chk("word before deselect", w[3], rdw);
         step(4'hF, 36'h000000000);
         chk("deselect drive", 36'h000000000, 36'(oe));
      end
      rd(19'h00020);
      idle(); // deselected ahead of sleep
      ctl.sleep_request_o = 1'b1;
      #1;
      chk("sleep drive", 36'h000000000, 36'(oe));
      @(posedge sys_clk_i);
      #1;
      idle();
      ctl.sleep_request_o = 1'b0;
      idle();
      rd(19'h00021);
      idle();
      chk("word after sleep", w[1], rdw);
   endtask

   initial begin
      n_fail = 0;
      comparisons = 0;
      reset_n_i = 1'b0;
      repeat (3) @(posedge sys_clk_i);
      #1;
      reset_n_i = 1'b1;
      chk("drive after reset", 36'h000000000, 36'(oe));
      t_bytes();
      t_burst();
      t_oe_stall();
      t_desel_sleep();
      give_verdict();
   end
   // bound on the whole run
   initial begin
      repeat (2000) @(posedge sys_clk_i);
      $display("Error run bound expected finish seen timeout");
      n_fail++;
      give_verdict();
   end
endmodule
`default_nettype wire
